// ### eact_pkg.sv
// Purpose: constants for the elapsed and countdown timer block
// Assumes: 50 MHz ref_clk, byte-wide registers reached by decoded serial accesses
// Notes:   counts derived from the 32768 Hz time base
// Functional notes
// - countdown steps at 1 Hz, or 32768 Hz when its fast-rate bit is set
// - countdown pause bit freezes the count while enabled; clearing resumes
// - countdown held at 0x3f while its enable bit is 0
// - writing 1 to countdown reload loads 0x3f when enabled; not stored
// - countdown stops at 0x00 and raises the countdown zero fault
// - elapsed timer steps at 1 Hz, or 32768 Hz when its fast-rate bit is set
// - elapsed pause bit holds the count while enabled; clearing resumes
// - elapsed timer held at 0x000000 while its enable bit is 0
// - writing 1 to elapsed clear zeroes the count when enabled; not stored
// - elapsed timer stops at 0xffffff and raises the overflow fault
// - full-shutdown 0: both wakes low keep always-on and elapsed timer alive
// - full-shutdown 1: both wakes low power everything down, elapsed disabled
// - control and power-mode writable bits reset to 0
// - countdown alarm raised at zero only when the alarm gate bit is 1
package eact_pkg;
	localparam logic [7:0]  ADDR_POWER_MODE  = 8'h48;
	localparam logic [7:0]  ADDR_TIMER_CTRL  = 8'h60;
	localparam logic [7:0]  ADDR_TIMER_STAT  = 8'h61;
	// timer_control field positions
	localparam int          CD_FAST_BIT      = 7;
	localparam int          CD_PAUSE_BIT     = 6;
	localparam int          CD_RELOAD_BIT    = 5;
	localparam int          CD_ON_BIT        = 4;
	localparam int          ET_FAST_BIT      = 3;
	localparam int          ET_PAUSE_BIT     = 2;
	localparam int          ET_CLEAR_BIT     = 1;
	localparam int          ET_ON_BIT        = 0;
	localparam logic [7:0]  CTRL_STORE_MASK  = 8'hdd;
	// timer_status field positions, then the power-mode full-shutdown bit
	localparam int          CD_RUN_BIT       = 7;
	localparam int          CD_GATE_BIT      = 4;
	localparam int          ET_RUN_BIT       = 3;
	localparam int          FULL_OFF_BIT     = 0;
	localparam logic [7:0]  CTRL_RESET       = 8'h00;
	localparam logic        PMODE_RESET      = 1'b0;
	// regulators are on out of reset, timer-only state is off
	localparam logic        PWR_ON_RESET     = 1'b1;
	localparam logic [5:0]  CD_FULL          = 6'h3f;
	localparam logic [5:0]  CD_EMPTY         = 6'h00;
	localparam logic [23:0] ET_ZERO          = 24'h00_0000;
	localparam logic [23:0] ET_FULL          = 24'hff_ffff;
	// time base: fractional accumulator, adds FAST_HZ each cycle modulo CLK_HZ
	localparam int          CLK_HZ           = 50_000_000;
	localparam int          FAST_HZ          = 32_768;
	localparam logic [25:0] ACC_STEP         = 26'(FAST_HZ);
	localparam logic [25:0] ACC_MOD          = 26'(CLK_HZ);
	localparam logic [14:0] PRE_LAST         = 15'(FAST_HZ - 1);
endpackage

// ### eact_tb.sv
// Purpose: self-checking bench for the elapsed and countdown timer block
// Assumes: fast-rate steps every 1525 or 1526 cycles of a 50 MHz ref_clk
// Notes:   register reads are noted in a queue and checked by a monitor process
`timescale 1ns/1ps
module tb;
	logic        ref_clk = 1'b0;
	logic        reset = 1'b1;
	logic [7:0]  reg_addr = 8'h00;
	logic [7:0]  reg_wdata = 8'h00;
	logic        reg_write = 1'b0;
	logic        reg_read = 1'b0;
	logic [7:0]  reg_rdata;
	logic        wake1_pin = 1'b1;
	logic        wake2_pin = 1'b0;
	logic        sw_on, ldo_on, aon_on, tonly, ovf, zero, alarm;
	logic [23:0] et_cnt;
	logic [5:0]  cd_cnt;
	logic [7:0]  rq[$];
	logic [23:0] hold_et;
	logic [5:0]  hold_cd;
	int          n_errors = 0;
	int          num_checks = 0;
	int          cyc = 0;
	int          n;

	always #10 ref_clk = ~ref_clk;

	eact_timer eact_timer_inst (.ref_clk(ref_clk), .reset(reset), .reg_addr(reg_addr),
		.reg_wdata(reg_wdata), .reg_write(reg_write), .reg_read(reg_read),
		.reg_rdata(reg_rdata), .wake1_pin(wake1_pin), .wake2_pin(wake2_pin),
		.switching_regs_on(sw_on), .ldo_group_on(ldo_on), .always_on_regulator_on(aon_on),
		.timer_only_state(tonly), .elapsed_count(et_cnt), .countdown_count(cd_cnt),
		.elapsed_overflow_fault(ovf), .countdown_zero_fault(zero), .countdown_alarm(alarm));

	task chk(input logic [23:0] got, input logic [23:0] exp, input string m);
		num_checks++;
		if (got !== exp) begin
			n_errors++;
			$display("[FAIL] %0t %s", $time, m);
		end
	endtask

	task test_done();
		$display("checks %0d mismatches %0d", num_checks, n_errors);
		if (n_errors == 0 && num_checks > 0)
			$display("[ PASS ]");
		else
			$display("[ FAIL ]");
		$finish;
	endtask

	task tick(input int k);
		repeat (k) @(posedge ref_clk);
		#1;
	endtask

	task wr(input logic [7:0] a, input logic [7:0] d);
		reg_addr = a;
		reg_wdata = d;
		reg_write = 1'b1;
		tick(1);
		reg_write = 1'b0;
	endtask

	task rd(input logic [7:0] a, input logic [7:0] exp);
		reg_addr = a;
		reg_read = 1'b1;
		rq.push_back(exp);
		tick(1);
		reg_read = 1'b0;
		tick(1);
	endtask

	// waits for the next elapsed step and returns the cycles it took
	task wait_chg(output int k);
		logic [23:0] v;
		v = et_cnt;
		k = 0;
		while (et_cnt === v && k < 3000) begin
			tick(1);
			k++;
		end
	endtask

	// read data is valid in the cycle after the sampling edge
	always @(posedge ref_clk) begin
		if (reg_read === 1'b1) begin
			#2;
			chk(reg_rdata, rq.pop_front(), "read data");
		end
	end

	always @(posedge ref_clk) begin
		cyc++;
		if (cyc == 110000) begin
			n_errors++;
			$display("[FAIL] %0t timeout", $time);
			test_done();
		end
	end

	initial begin
		void'($urandom(35341));
		tick(4);
		reset = 1'b0;
		rd(8'h60, 8'h00);
		rd(8'h48, 8'h00);
		rd(8'h61, 8'h00);
		chk(cd_cnt, 24'h00_003f, "countdown not full after reset");
		chk(et_cnt, 24'h00_0000, "elapsed not zero after reset");
		wr(8'h50, 8'($urandom));
		rd(8'h50, 8'h00);
		$display("reset test done");
		wr(8'h60, 8'h99);
		rd(8'h60, 8'h99);
		wait_chg(n);
		wait_chg(n);
		chk(24'(n >= 1525 && n <= 1527), 24'h00_0001, "fast step interval");
		chk(24'(cd_cnt) + et_cnt, 24'h00_003f, "countdown and elapsed out of step");
		$display("rate test done");
		wr(8'h60, 8'hdd);
		tick(2);
		hold_et = et_cnt;
		hold_cd = cd_cnt;
		tick(1600);
		chk(et_cnt, hold_et, "elapsed moved while paused");
		chk(cd_cnt, hold_cd, "countdown moved while paused");
		wr(8'h60, 8'h99);
		wait_chg(n);
		chk(24'(n < 3000), 24'h00_0001, "elapsed did not resume");
		wr(8'h60, 8'hbb);
		chk(cd_cnt, 24'h00_003f, "reload");
		chk(et_cnt, 24'h00_0000, "clear");
		rd(8'h60, 8'h99);
		$display("pause and reload test done");
		wr(8'h61, 8'h10);
		n = 0;
		while (cd_cnt !== 6'h00 && n < 100000) begin
			tick(1);
			n++;
		end
		tick(2);
		chk(cd_cnt, 24'h00_0000, "countdown left zero");
		chk(zero, 1'b1, "zero fault");
		chk(alarm, 1'b1, "gated alarm");
		wr(8'h61, 8'h00);
		tick(2);
		chk(alarm, 1'b0, "alarm with gate clear");
		wr(8'h60, 8'h00);
		tick(2);
		chk(cd_cnt, 24'h00_003f, "disabled countdown");
		chk(et_cnt, 24'h00_0000, "disabled elapsed");
		$display("zero test done");
		wr(8'h60, 8'h09);
		wake1_pin = 1'b0;
		tick(6);
		chk({sw_on, ldo_on, aon_on, tonly}, 24'h00_0003, "timer-only state");
		wait_chg(n);
		chk(24'(n < 3000), 24'h00_0001, "elapsed stopped in timer-only");
		wake1_pin = 1'($urandom);
		wake2_pin = ~wake1_pin;
		tick(6);
		chk({sw_on, ldo_on, aon_on, tonly}, 24'h00_000e, "wake");
		wr(8'h48, 8'h01);
		rd(8'h48, 8'h01);
		{wake1_pin, wake2_pin} = 2'b00;
		tick(6);
		chk({sw_on, ldo_on, aon_on, tonly}, 24'h00_0000, "full shutdown");
		chk(et_cnt, 24'h00_0000, "elapsed in full shutdown");
		$display("power mode test done");
		test_done();
	end
endmodule // tb

// ### eact_timer.sv
// Purpose: elapsed up-timer, countdown timer and wake-pin power-mode decision
// Assumes: register port is the decoded output of the serial interface
// Notes:   read data valid one cycle after reg_read
`timescale 1ns/1ps
module eact_timer (
	// clock and reset
	input  wire logic        ref_clk,
	input  wire logic        reset,
	// register port
	input  wire logic [7:0]  reg_addr,
	input  wire logic [7:0]  reg_wdata,
	input  wire logic        reg_write,
	input  wire logic        reg_read,
	output logic      [7:0]  reg_rdata,
	// wake pins
	input  wire logic        wake1_pin,
	input  wire logic        wake2_pin,
	// power outputs
	output logic             switching_regs_on,
	output logic             ldo_group_on,
	output logic             always_on_regulator_on,
	output logic             timer_only_state,
	// timer status
	output logic      [23:0] elapsed_count,
	output logic      [5:0]  countdown_count,
	output logic             elapsed_overflow_fault,
	output logic             countdown_zero_fault,
	output logic             countdown_alarm
);
	typedef struct packed {
		logic [1:0]  wake_meta;
		logic [1:0]  wake_sync;
		logic [25:0] acc;
		logic [14:0] pre;
		logic        fast_tick;
		logic        slow_tick;
		logic [7:0]  ctrl;
		logic        full_off;
		logic        gate;
		logic        asleep;
		logic [5:0]  cd;
		logic [23:0] et;
		logic        et_fault;
		logic        cd_fault;
		logic        alarm;
		logic [7:0]  rdata;
		// power outputs, registered in step with asleep
		logic        sw_on;
		logic        ldo_on;
		logic        aon_on;
		logic        tonly;
	} eact_state_t;

	eact_state_t st;
	eact_state_t next_st;

	function automatic logic hit(input logic [7:0] a, input logic [7:0] want);
		return a == want;
	endfunction

	logic wr_ctrl;
	logic wr_stat;
	logic wr_pmode;
	logic cd_en;
	logic et_en;
	logic cd_step;
	logic et_step;

	always_comb begin
		next_st = st;
		wr_ctrl = reg_write && hit(reg_addr, eact_pkg::ADDR_TIMER_CTRL);
		wr_stat = reg_write && hit(reg_addr, eact_pkg::ADDR_TIMER_STAT);
		wr_pmode = reg_write && hit(reg_addr, eact_pkg::ADDR_POWER_MODE);
		// wake pins through two flops
		next_st.wake_meta = {wake2_pin, wake1_pin};
		next_st.wake_sync = st.wake_meta;
		// 32768 Hz strobe, then 15-bit prescaler to 1 Hz
		next_st.fast_tick = 1'b0;
		next_st.slow_tick = 1'b0;
		if (st.acc + eact_pkg::ACC_STEP >= eact_pkg::ACC_MOD) begin
			next_st.acc = st.acc + eact_pkg::ACC_STEP - eact_pkg::ACC_MOD;
			next_st.fast_tick = 1'b1;
			next_st.pre = (st.pre == eact_pkg::PRE_LAST) ? 15'h0000 : st.pre + 15'h0001;
			next_st.slow_tick = (st.pre == eact_pkg::PRE_LAST);
		end else begin
			next_st.acc = st.acc + eact_pkg::ACC_STEP;
		end
		// register writes; one-shot bits never stored
		if (wr_ctrl) begin
			next_st.ctrl = reg_wdata & eact_pkg::CTRL_STORE_MASK;
		end
		if (wr_stat) begin
			next_st.gate = reg_wdata[eact_pkg::CD_GATE_BIT];
		end
		if (wr_pmode) begin
			next_st.full_off = reg_wdata[eact_pkg::FULL_OFF_BIT];
		end
		// both wakes low enters low-power state, any wake high leaves it
		next_st.asleep = (st.wake_sync == 2'b00);
		// outputs follow the next state so they change on the same edge as asleep
		next_st.sw_on = !next_st.asleep;
		next_st.ldo_on = !next_st.asleep;
		next_st.aon_on = !(next_st.asleep && next_st.full_off);
		next_st.tonly = next_st.asleep && !next_st.full_off;
		cd_en = st.ctrl[eact_pkg::CD_ON_BIT];
		et_en = st.ctrl[eact_pkg::ET_ON_BIT] && !(st.asleep && st.full_off);
		cd_step = st.ctrl[eact_pkg::CD_FAST_BIT] ? st.fast_tick : st.slow_tick;
		et_step = st.ctrl[eact_pkg::ET_FAST_BIT] ? st.fast_tick : st.slow_tick;
		// countdown
		if (!cd_en) begin
			next_st.cd = eact_pkg::CD_FULL;
		end else if (wr_ctrl && reg_wdata[eact_pkg::CD_RELOAD_BIT]) begin
			next_st.cd = eact_pkg::CD_FULL;
		end else if (cd_step && !st.ctrl[eact_pkg::CD_PAUSE_BIT]
				&& st.cd != eact_pkg::CD_EMPTY) begin
			next_st.cd = st.cd - 6'h01;
		end
		// elapsed timer
		if (!et_en) begin
			next_st.et = eact_pkg::ET_ZERO;
		end else if (wr_ctrl && reg_wdata[eact_pkg::ET_CLEAR_BIT]) begin
			next_st.et = eact_pkg::ET_ZERO;
		end else if (et_step && !st.ctrl[eact_pkg::ET_PAUSE_BIT]
				&& st.et != eact_pkg::ET_FULL) begin
			next_st.et = st.et + 24'h00_0001;
		end
		next_st.cd_fault = cd_en && st.cd == eact_pkg::CD_EMPTY;
		next_st.et_fault = et_en && st.et == eact_pkg::ET_FULL;
		next_st.alarm = cd_en && st.cd == eact_pkg::CD_EMPTY && st.gate;
		// read path
		next_st.rdata = 8'h00;
		if (reg_read) begin
			if (hit(reg_addr, eact_pkg::ADDR_TIMER_CTRL)) begin
				next_st.rdata = st.ctrl;
			end else if (hit(reg_addr, eact_pkg::ADDR_POWER_MODE)) begin
				next_st.rdata[eact_pkg::FULL_OFF_BIT] = st.full_off;
			end else if (hit(reg_addr, eact_pkg::ADDR_TIMER_STAT)) begin
				next_st.rdata[eact_pkg::CD_RUN_BIT] = cd_en && !st.ctrl[eact_pkg::CD_PAUSE_BIT]
					&& st.cd != eact_pkg::CD_EMPTY;
				next_st.rdata[eact_pkg::CD_GATE_BIT] = st.gate;
				next_st.rdata[eact_pkg::ET_RUN_BIT] = et_en && !st.ctrl[eact_pkg::ET_PAUSE_BIT]
					&& st.et != eact_pkg::ET_FULL;
			end
		end
	end

	always_ff @(posedge ref_clk) begin
		if (reset) begin
			st <= '0;
			st.ctrl <= eact_pkg::CTRL_RESET;
			st.full_off <= eact_pkg::PMODE_RESET;
			st.cd <= eact_pkg::CD_FULL;
			st.sw_on <= eact_pkg::PWR_ON_RESET;
			st.ldo_on <= eact_pkg::PWR_ON_RESET;
			st.aon_on <= eact_pkg::PWR_ON_RESET;
		end else begin
			st <= next_st;
		end
	end

	assign reg_rdata              = st.rdata;
	assign switching_regs_on      = st.sw_on;
	assign ldo_group_on           = st.ldo_on;
	assign always_on_regulator_on = st.aon_on;
	assign timer_only_state       = st.tonly;
	assign elapsed_count          = st.et;
	assign countdown_count        = st.cd;
	assign elapsed_overflow_fault = st.et_fault;
	assign countdown_zero_fault   = st.cd_fault;
	assign countdown_alarm        = st.alarm;

	default clocking cb @(posedge ref_clk); endclocking
	default disable iff (reset);

	cd_held_full_a: assert property (!st.ctrl[eact_pkg::CD_ON_BIT] |=> st.cd == 6'h3f)
		else $error("countdown not held full while disabled");
	cd_pause_a: assert property (
		st.ctrl[eact_pkg::CD_PAUSE_BIT] && st.ctrl[eact_pkg::CD_ON_BIT]
		&& !(wr_ctrl && reg_wdata[eact_pkg::CD_RELOAD_BIT]) |=> $stable(st.cd))
		else $error("countdown moved while paused");
	cd_reload_a: assert property (
		st.ctrl[eact_pkg::CD_ON_BIT] && wr_ctrl
		&& reg_wdata[eact_pkg::CD_RELOAD_BIT] |=> st.cd == 6'h3f
		&& !st.ctrl[eact_pkg::CD_RELOAD_BIT])
		else $error("countdown reload failed");
	countdown_zero_fault_a: assert property (
		st.ctrl[eact_pkg::CD_ON_BIT] && st.cd == 6'h00
		&& !wr_ctrl |=> st.cd == 6'h00 ##1 countdown_zero_fault)
		else $error("countdown left zero or no fault");
	cd_rate_a: assert property (
		cd_step |-> (st.ctrl[eact_pkg::CD_FAST_BIT] ? st.fast_tick
		: st.slow_tick && st.pre == 15'h0000))
		else $error("countdown step at wrong rate");
	et_held_zero_a: assert property (!st.ctrl[eact_pkg::ET_ON_BIT] |=> st.et == 24'h00_0000)
		else $error("elapsed timer not held at zero");
	et_pause_a: assert property (
		et_en && st.ctrl[eact_pkg::ET_PAUSE_BIT] && !wr_ctrl
		|=> $stable(st.et))
		else $error("elapsed timer moved while paused");
	et_clear_a: assert property (
		et_en && wr_ctrl && reg_wdata[eact_pkg::ET_CLEAR_BIT]
		|=> st.et == 24'h00_0000 && !st.ctrl[eact_pkg::ET_CLEAR_BIT])
		else $error("elapsed clear failed");
	et_saturate_a: assert property (
		et_en && st.et == 24'hff_ffff && !wr_ctrl && !st.asleep
		|=> st.et == 24'hff_ffff ##1 elapsed_overflow_fault)
		else $error("elapsed timer passed saturation");
	et_rate_a: assert property (
		et_step |-> (st.ctrl[eact_pkg::ET_FAST_BIT] ? st.fast_tick
		: st.slow_tick && st.pre == 15'h0000))
		else $error("elapsed step at wrong rate");
	sleep_power_a: assert property (
		st.wake_sync == 2'b00 ##1 st.wake_sync == 2'b00
		|-> !switching_regs_on && (always_on_regulator_on == !st.full_off))
		else $error("low-power state wrong");
	wake_power_a: assert property (
		st.wake_sync != 2'b00 |=> switching_regs_on && ldo_group_on
		&& always_on_regulator_on && !timer_only_state)
		else $error("regulators off while awake");
	full_off_et_a: assert property (st.asleep && st.full_off |=> st.et == 24'h00_0000)
		else $error("elapsed timer alive in full shutdown");
	alarm_gate_a: assert property (
		countdown_alarm |-> $past(st.gate)
		&& $past(st.cd) == 6'h00)
		else $error("countdown alarm without gate");
	tick_once_a: assert property (st.fast_tick |=> !st.fast_tick)
		else $error("fast tick longer than one cycle");

	cd_reaches_zero_c: cover property (st.ctrl[eact_pkg::CD_ON_BIT] ##1 countdown_zero_fault);
	et_overflow_c: cover property (elapsed_overflow_fault);
	timer_only_c: cover property (timer_only_state ##1 !timer_only_state);
	alarm_c: cover property (countdown_alarm);
	full_off_c: cover property (!always_on_regulator_on);
endmodule // eact_timer
